// >>> bench/fswp_spi_master.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Bus master model: mode 0 link, clock stands low outside frames.
// ----------------------------------------------------------------------
module fswp_spi_master (
   input wire logic core_clk,
   input wire logic dataOut,
   output logic spiClk,
   output logic chipSelN,
   output logic serialIoLine
);
   // Half period of the link clock in core cycles, giving 80 ns.
   localparam int HALF = 8;

   // Idle levels at time zero: deselected, clock low.
   initial begin
      spiClk = 1'b0;
      chipSelN = 1'b1;
      serialIoLine = 1'b1;
   end

   // Sends nb bits MSB first and gathers read data on each rising edge.
   // The data line is set half a period before the edge so it is stable.
   task automatic frame(input logic [47:0] tx, input int nb, output logic [47:0] rx);
      rx = 48'h0;
      @(posedge core_clk) #1 chipSelN = 1'b0;
      for (int i = nb - 1; i >= 0; i--) begin
         repeat (HALF) @(posedge core_clk);
         #1 spiClk = 1'b0;
         serialIoLine = tx[i];
         repeat (HALF) @(posedge core_clk);
         #1 spiClk = 1'b1;
         rx = {rx[46:0], dataOut};
      end
      repeat (HALF) @(posedge core_clk);
      #1 spiClk = 1'b0;
      repeat (HALF) @(posedge core_clk);
      #1 chipSelN = 1'b1;
      // A released line must not keep showing the last bit.
      serialIoLine = ~serialIoLine;
      // Leaves time for the block to act on the select rise.
      repeat (8) @(posedge core_clk);
   endtask
endmodule // fswp_spi_master

// >>> bench/test_flash_status_write_protect.sv
`timescale 1ns/10ps
`include "fswp_defs.svh"
// ----------------------------------------------------------------------
// Self-checking bench for the status and protection block.
// ----------------------------------------------------------------------
module test_flash_status_write_protect
   import fswp_pkg::*;
;
   logic core_clk, rst_n, lockPinN, spiClk, chipSelN, serialIoLine;
   logic dataOut, dataOutEn, arrayGo;
   logic [1:0] densitySel;
   logic [7:0] statusByte;
   fswp_arr_t arrayOp;
   logic [23:0] arrayAddr;
   logic [47:0] rxd;
   int errors, checks, goCnt;

   // Clock enable is tied high; freezing is outside this bench.
   fswp_status_protect DUT (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1),
      .spiClk(spiClk), .chipSelN(chipSelN), .serialIoLine(serialIoLine),
      .lockPinN(lockPinN), .densitySel(densitySel), .dataOut(dataOut),
      .dataOutEn(dataOutEn), .statusByte(statusByte), .arrayGo(arrayGo),
      .arrayOp(arrayOp), .arrayAddr(arrayAddr));
   fswp_spi_master M (.core_clk(core_clk), .dataOut(dataOut), .spiClk(spiClk),
      .chipSelN(chipSelN), .serialIoLine(serialIoLine));

   // 100 MHz core clock.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Counts accepted array operations as single-cycle pulses.
   always @(posedge core_clk) begin
      if (arrayGo === 1'b1) begin
         goCnt++;
      end
   end

   // ----------------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic send(input logic [47:0] tx, input int nb);
      M.frame(tx, nb, rxd);
   endtask

   // Polls the busy flag under a bound longer than the longest cycle.
   task automatic wait_idle();
      for (int n = 0; n < 6000 && statusByte[0] !== 1'b0; n++) begin
         @(posedge core_clk);
      end
      check(48'(statusByte[0]), 48'h0);
   endtask

   task automatic set_status(input logic [7:0] v);
      send(48'(`FSWP_OPC_WREN), 8);
      send(48'({`FSWP_OPC_WRSR, v}), 16);
      wait_idle();
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   // ----------------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------------
   task automatic t_reset();
      check(48'(statusByte), 48'h0);
      check(48'(dataOutEn), 48'h0);
      done("reset");
   endtask

   // Latch set and cleared; status read repeats while selected.
   task automatic t_latch();
      send(48'(`FSWP_OPC_WREN), 8);
      check(48'(statusByte), 48'h2);
      send(48'({`FSWP_OPC_RDSR, 16'h0}), 24);
      check(48'(rxd[15:0]), 48'h0202);
      send(48'(`FSWP_OPC_WRDI), 8);
      check(48'(statusByte), 48'h0);
      done("latch");
   endtask

   // Status write with the lock bit clear and the pin low: pin ignored.
   task automatic t_wrsr();
      send(48'(`FSWP_OPC_WREN), 8);
      send(48'({`FSWP_OPC_WRSR, 8'h7F}), 16);
      check(48'(statusByte[1:0]), 48'h1);
      send(48'({`FSWP_OPC_RDSR, 8'h0}), 16);
      check(48'(rxd[7:0]), 48'h3D);
      check(48'(rxd[7:0] & 8'hBF), 48'h3D);
      send(48'(`FSWP_OPC_WREN), 8);
      check(48'(statusByte[1]), 48'h0);
      wait_idle();
      check(48'(statusByte), 48'h3C);
      done("status write");
   endtask

   // A select rise in mid-byte abandons the status write.
   task automatic t_partial();
      send(48'(`FSWP_OPC_WREN), 8);
      send(48'(12'h010), 12);
      check(48'(statusByte), 48'h3E);
      send(48'({`FSWP_OPC_WRSR, 8'h00}), 16);
      wait_idle();
      check(48'(statusByte), 48'h0);
      done("partial byte");
   endtask

   // Lock bit set: low pin refuses, high pin accepts.
   task automatic t_lock();
      set_status(8'h80);
      check(48'(statusByte), 48'h80);
      send(48'(`FSWP_OPC_WREN), 8);
      send(48'({`FSWP_OPC_WRSR, 8'h84}), 16);
      check(48'(statusByte), 48'h82);
      @(posedge core_clk) #1 lockPinN = 1'b1;
      repeat (6) @(posedge core_clk);
      send(48'({`FSWP_OPC_WRSR, 8'h24}), 16);
      wait_idle();
      check(48'(statusByte), 48'h24);
      set_status(8'h00);
      @(posedge core_clk) #1 lockPinN = 1'b0;
      done("lock");
   endtask

   // One program attempt against a guard setting and density.
   task automatic t_range(input logic [1:0] den, input logic [7:0] st,
         input logic [23:0] addr, input logic ok);
      int g0;
      @(posedge core_clk) #1 densitySel = den;
      repeat (6) @(posedge core_clk);
      set_status(st);
      send(48'(`FSWP_OPC_WREN), 8);
      g0 = goCnt;
      send(48'({`FSWP_OPC_PROG, addr, 8'hA5}), 40);
      check(48'(goCnt - g0), 48'(ok));
      if (ok) begin
         check(48'(arrayOp), 48'(FSWP_ARR_PROG));
         check(48'(arrayAddr), 48'(addr));
         check(48'(statusByte[1:0]), 48'h1);
         wait_idle();
      end else begin
         check(48'(statusByte[1:0]), 48'h2);
         send(48'(`FSWP_OPC_WRDI), 8);
      end
   endtask

   // Chip erase: refused under the smallest guard, accepted with none.
   task automatic t_erase();
      int g0;
      set_status(8'h04);
      send(48'(`FSWP_OPC_WREN), 8);
      g0 = goCnt;
      send(48'(`FSWP_OPC_CE1), 8);
      check(48'(goCnt - g0), 48'h0);
      set_status(8'h00);
      send(48'(`FSWP_OPC_WREN), 8);
      send(48'(`FSWP_OPC_CE2), 8);
      check(48'(goCnt - g0), 48'h1);
      check(48'(arrayOp), 48'(FSWP_ARR_CHIP));
      wait_idle();
      done("chip erase");
   endtask

   // Identification reads at the largest density.
   task automatic t_ids();
      logic [7:0] ops[3] = '{`FSWP_OPC_DEVID, `FSWP_OPC_MFID, `FSWP_OPC_MFID2};
      logic [15:0] exp[3] = '{{`FSWP_DEV_4M, `FSWP_DEV_4M},
         {`FSWP_MAKER_CODE, `FSWP_DEV_4M}, {`FSWP_MAKER_CODE, `FSWP_DEV_4M}};
      @(posedge core_clk) #1 densitySel = `FSWP_DEN_4M;
      repeat (6) @(posedge core_clk);
      for (int i = 0; i < 3; i++) begin
         send({ops[i], 40'h0}, 48);
         check(48'(rxd[15:0]), 48'(exp[i]));
      end
      send(48'({`FSWP_OPC_JEDEC, 24'h0}), 32);
      check(48'(rxd[23:0]), 48'({`FSWP_MAKER_CODE, `FSWP_JDEV_4M}));
      done("identification");
   endtask

   // ----------------------------------------------------------------------
   // Verdict, watchdog and main sequence.
   // ----------------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // A clean run needs about half of this span.
   initial begin
      #900_000;
      errors++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      lockPinN = 1'b0;
      densitySel = `FSWP_DEN_4M;
      errors = 0;
      checks = 0;
      goCnt = 0;
      repeat (6) @(posedge core_clk);
      #1 rst_n = 1'b1;
      repeat (8) @(posedge core_clk);
      t_reset();
      t_latch();
      t_wrsr();
      t_partial();
      t_lock();
      t_range(`FSWP_DEN_4M, 8'h04, 24'h07_0000, 1'b0);
      t_range(`FSWP_DEN_4M, 8'h04, 24'h06_FFFF, 1'b1);
      t_range(`FSWP_DEN_4M, 8'h2C, 24'h03_FFFF, 1'b0);
      t_range(`FSWP_DEN_4M, 8'h2C, 24'h04_0000, 1'b1);
      t_range(`FSWP_DEN_4M, 8'h10, 24'h00_0000, 1'b0);
      t_range(`FSWP_DEN_2M, 8'h18, 24'h02_0000, 1'b0);
      t_range(`FSWP_DEN_2M, 8'h18, 24'h01_FFFF, 1'b1);
      t_range(`FSWP_DEN_1M, 8'h24, 24'h00_FFFF, 1'b0);
      t_range(`FSWP_DEN_1M, 8'h24, 24'h01_0000, 1'b1);
      t_range(`FSWP_DEN_1M, 8'h08, 24'h01_FFFF, 1'b0);
      done("range decode");
      t_erase();
      set_status(8'h00);
      t_ids();
      give_verdict();
   end
endmodule // test_flash_status_write_protect

// >>> design/fswp_defs.svh
// Function
// - Busy flag at S0 during program, erase, status write
// - While busy, only status read is answered
// - Busy clears when the operation completes
// - Write latch flag at S1 set by write enable
// - Write latch cleared at reset, disable, executed writes
// - Three guard bits at S4..S2, status write only
// - Guard bits leave reset at zero
// - Guard bits locked when lock bit and pin low
// - Selector zero guards top, one guards bottom
// - Selector resets zero, needs write enable, same lock
// - Reserved bit S6 always reads zero
// - Lock bit at S7 resets zero, pin ignored then
// - Lock bit one: pin low rejects, high accepts
// - Four megabit range decode table
// - Two megabit range decode, top guard bit ignored
// - One megabit range decode
// - Select fall starts, opcode MSB first on rise
// - Writes abandoned unless select rises on byte boundary
// - Maker and device codes for identification opcodes
// - Opcode 06h sets the write latch
// - Status read repeats MSB first until deselect
// - Lock pin is active low
`ifndef FSWP_DEFS_SVH
`define FSWP_DEFS_SVH

// ----------------------------------------------------------------------
// Instruction codes.
// ----------------------------------------------------------------------
`define FSWP_OPC_WREN 8'h06
`define FSWP_OPC_WRDI 8'h04
`define FSWP_OPC_RDSR 8'h05
`define FSWP_OPC_WRSR 8'h01
`define FSWP_OPC_PROG 8'h02
`define FSWP_OPC_SE 8'h20
`define FSWP_OPC_BE32 8'h52
`define FSWP_OPC_BE64 8'hD8
`define FSWP_OPC_CE1 8'hC7
`define FSWP_OPC_CE2 8'h60
`define FSWP_OPC_DEVID 8'hAB
`define FSWP_OPC_MFID 8'h90
`define FSWP_OPC_MFID2 8'h92
`define FSWP_OPC_JEDEC 8'h9F

// ----------------------------------------------------------------------
// Status byte field positions and reset values.
// ----------------------------------------------------------------------
`define FSWP_S_BUSY 0
`define FSWP_S_WEL 1
`define FSWP_S_GLO 2
`define FSWP_S_GHI 4
`define FSWP_S_TB 5
`define FSWP_S_RSV 6
`define FSWP_S_LOCK 7
`define FSWP_GUARD_RST 3'h0
`define FSWP_TB_RST 1'h0
`define FSWP_LOCK_RST 1'h0

// ----------------------------------------------------------------------
// Density straps and identification codes (code values are arbitrary).
// ----------------------------------------------------------------------
`define FSWP_DEN_1M 2'h0
`define FSWP_DEN_2M 2'h1
`define FSWP_DEN_4M 2'h2
`define FSWP_MAKER_CODE 8'h5A
`define FSWP_DEV_1M 8'hA1
`define FSWP_DEV_2M 8'hA2
`define FSWP_DEV_4M 8'hA3
`define FSWP_JDEV_1M 16'hC0A1
`define FSWP_JDEV_2M 16'hC0A2
`define FSWP_JDEV_4M 16'hC0A3

// ----------------------------------------------------------------------
// Busy times in ns and their cycle counts at the core clock.
// ----------------------------------------------------------------------
`define FSWP_CLK_NS 10
`define FSWP_TW_NS 10000
`define FSWP_TPP_NS 5000
`define FSWP_TE_NS 40000
`define FSWP_TW_CYC ((`FSWP_TW_NS + `FSWP_CLK_NS - 1) / `FSWP_CLK_NS)
`define FSWP_TPP_CYC ((`FSWP_TPP_NS + `FSWP_CLK_NS - 1) / `FSWP_CLK_NS)
`define FSWP_TE_CYC ((`FSWP_TE_NS + `FSWP_CLK_NS - 1) / `FSWP_CLK_NS)

`endif

// >>> design/fswp_pkg.sv
// ----------------------------------------------------------------------
// Types shared by the status and protection logic.
// ----------------------------------------------------------------------
package fswp_pkg;

   // Kind of array operation handed to the array controller.
   typedef enum logic [1:0] {
      FSWP_ARR_PROG,
      FSWP_ARR_SECT,
      FSWP_ARR_BLOCK,
      FSWP_ARR_CHIP
   } fswp_arr_t;

   // State of the block except the reset release, registered in one place.
   typedef struct packed {
      logic csN1;
      logic csN2;
      logic csN3;
      logic sck1;
      logic sck2;
      logic sck3;
      logic din1;
      logic din2;
      logic lock1;
      logic lock2;
      logic [1:0] den1;
      logic [1:0] den2;
      logic [2:0] bitPos;
      logic [3:0] byteNum;
      logic [7:0] shiftIn;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] wrData;
      logic busy;
      logic write_latch_flag;
      logic [2:0] guard;
      logic guardEnd;
      logic lockBit;
      logic [11:0] busyCnt;
      logic dataOut;
      logic dataOutEn;
      logic arrayGo;
      fswp_arr_t arrayOp;
      logic [23:0] arrayAddr;
   } fswp_state_t;

endpackage

// >>> design/fswp_status_protect.sv
`timescale 1ns/10ps
`include "fswp_defs.svh"

module fswp_status_protect
   import fswp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic spiClk,
   input wire logic chipSelN,
   input wire logic serialIoLine,
   input wire logic lockPinN,
   input wire logic [1:0] densitySel,
   output logic dataOut,
   output logic dataOutEn,
   output logic [7:0] statusByte,
   output logic arrayGo,
   output fswp_arr_t arrayOp,
   output logic [23:0] arrayAddr
);

   // ----------------------------------------------------------------------
   // Reset release and state storage.
   // ----------------------------------------------------------------------
   logic [1:0] rstSync; // Release path for the outside reset.
   logic rstLocalN; // Reset copy used by all other state.
   fswp_state_t s; // Registered state.
   fswp_state_t next_s; // Next value of the state.

   // Helper terms, all decoded from registered state.
   logic selected; // Chip select seen low after synchronising.
   logic csFall; // Start of an instruction.
   logic csRise; // End of an instruction.
   logic sckRise; // Sampling edge of the link clock.
   logic sckFall; // Shifting edge of the link clock.
   logic [7:0] byteVal; // Byte completed on this rising edge.
   logic wholeBytes; // Select rose after a whole number of bytes.
   logic locked; // Status writes are refused now.
   logic [8:0] rdSel; // Valid flag and byte to shift out.

   // The outside reset is released through two flip-flops so that the
   // release never lands near a clock edge of the main state.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstLocalN = rstSync[1];

   // ----------------------------------------------------------------------
   // Range decode.
   // ----------------------------------------------------------------------
   // Returns one when a 64KB block lies inside the guarded range. The block
   // number wraps at the density, as the array does for high addresses.
   function automatic logic fswpHit(input logic [1:0] den, input logic tb,
                                    input logic [2:0] bp, input logic [2:0] blkRaw);
      logic [3:0] total;
      logic [3:0] nBlk;
      logic [3:0] blk;
      total = 4'h8;
      nBlk = 4'h0;
      if (den == `FSWP_DEN_1M) begin
         total = 4'h2;
         nBlk = bp[1] ? 4'h2 : {3'h0, bp[0]};
      end else if (den == `FSWP_DEN_2M) begin
         total = 4'h4;
         unique case (bp[1:0]) // Top guard bit ignored.
            2'h0: nBlk = 4'h0;
            2'h1: nBlk = 4'h1;
            2'h2: nBlk = 4'h2;
            2'h3: nBlk = 4'h4;
         endcase
      end else begin
         unique casez (bp)
            3'b000: nBlk = 4'h0;
            3'b001: nBlk = 4'h1;
            3'b010: nBlk = 4'h2;
            3'b011: nBlk = 4'h4;
            3'b1??: nBlk = 4'h8;
         endcase
      end
      blk = {1'b0, blkRaw} & (total - 4'h1);
      // Selector zero grows from the top, one from the bottom.
      return tb ? (blk < nBlk) : (blk >= (total - nBlk));
   endfunction

   // ----------------------------------------------------------------------
   // Read data selection.
   // ----------------------------------------------------------------------
   // Picks the byte to shift for the byte now being clocked. Bit eight is
   // the valid flag; only the status read survives a busy cycle.
   function automatic logic [8:0] fswpRead(input logic [7:0] opc, input logic [3:0] num,
                                           input logic [7:0] stat, input logic [1:0] den,
                                           input logic bsy);
      logic [7:0] dev;
      logic [15:0] jdev;
      logic [3:0] idx;
      dev = (den == `FSWP_DEN_1M) ? `FSWP_DEV_1M :
            (den == `FSWP_DEN_2M) ? `FSWP_DEV_2M : `FSWP_DEV_4M;
      jdev = (den == `FSWP_DEN_1M) ? `FSWP_JDEV_1M :
             (den == `FSWP_DEN_2M) ? `FSWP_JDEV_2M : `FSWP_JDEV_4M;
      idx = num - 4'h4;
      fswpRead = 9'h000;
      if (num == 4'h0) begin
         fswpRead = 9'h000;
      end else if (opc == `FSWP_OPC_RDSR) begin
         fswpRead = {1'b1, stat}; // Repeats for every byte.
      end else if (bsy) begin
         fswpRead = 9'h000;
      end else if (opc == `FSWP_OPC_DEVID && num >= 4'h4) begin
         fswpRead = {1'b1, dev};
      end else if ((opc == `FSWP_OPC_MFID || opc == `FSWP_OPC_MFID2) && num >= 4'h4) begin
         fswpRead = {1'b1, idx[0] ? dev : `FSWP_MAKER_CODE};
      end else if (opc == `FSWP_OPC_JEDEC && num <= 4'h3) begin
         unique case (num[1:0])
            2'h1: fswpRead = {1'b1, `FSWP_MAKER_CODE};
            2'h2: fswpRead = {1'b1, jdev[15:8]};
            2'h3: fswpRead = {1'b1, jdev[7:0]};
            default: fswpRead = 9'h000;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // Edge and condition decode.
   // ----------------------------------------------------------------------
   assign selected = !s.csN2;
   assign csFall = s.csN3 && !s.csN2;
   assign csRise = !s.csN3 && s.csN2;
   assign sckRise = selected && s.sck2 && !s.sck3;
   assign sckFall = selected && !s.sck2 && s.sck3;
   assign byteVal = {s.shiftIn[6:0], s.din2};
   assign wholeBytes = (s.byteNum != 4'h0) && (s.bitPos == 3'h0);
   // The pin only matters once the lock bit is set; pin low means locked.
   assign locked = s.lockBit && !s.lock2;
   // Reserved bit forced to zero here so no write can reach it.
   assign statusByte = {s.lockBit, 1'b0, s.guardEnd, s.guard, s.write_latch_flag, s.busy};
   assign rdSel = fswpRead(s.opcode, s.byteNum, statusByte, s.den2, s.busy);

   // ----------------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------------
   // All inputs from the link pass two flip-flops; only the second stage
   // and the edge history stage are read by the decode above.
   always_comb begin
      next_s = s;
      next_s.arrayGo = 1'b0;
      next_s.csN1 = chipSelN;
      next_s.csN2 = s.csN1;
      next_s.csN3 = s.csN2;
      next_s.sck1 = spiClk;
      next_s.sck2 = s.sck1;
      next_s.sck3 = s.sck2;
      next_s.din1 = serialIoLine;
      next_s.din2 = s.din1;
      next_s.lock1 = lockPinN;
      next_s.lock2 = s.lock1;
      next_s.den1 = densitySel;
      next_s.den2 = s.den1;

      // Busy countdown; the flag drops once the count is spent.
      if (s.busy) begin
         if (s.busyCnt == 12'h000) begin
            next_s.busy = 1'b0;
         end else begin
            next_s.busyCnt = s.busyCnt - 12'h001;
         end
      end

      if (csFall) begin
         // A new instruction always starts from its first bit.
         next_s.bitPos = 3'h0;
         next_s.byteNum = 4'h0;
         next_s.dataOutEn = 1'b0;
      end else if (sckRise) begin
         // Shift in MSB first; a finished byte lands by its position.
         next_s.shiftIn = byteVal;
         next_s.bitPos = s.bitPos + 3'h1;
         if (s.bitPos == 3'h7) begin
            if (s.byteNum != 4'hF) begin
               next_s.byteNum = s.byteNum + 4'h1;
            end
            unique case (s.byteNum)
               4'h0: next_s.opcode = byteVal;
               4'h1: begin
                  next_s.addr[23:16] = byteVal;
                  next_s.wrData = byteVal;
               end
               4'h2: next_s.addr[15:8] = byteVal;
               4'h3: next_s.addr[7:0] = byteVal;
               default: next_s.addr = s.addr;
            endcase
         end
      end else if (sckFall) begin
         // Output bits change on the falling edge for the byte in flight.
         next_s.dataOutEn = rdSel[8];
         next_s.dataOut = rdSel[~s.bitPos] & rdSel[8];
      end

      if (csRise) begin
         next_s.dataOutEn = 1'b0;
         // Partial bytes and any instruction during busy are dropped.
         if (wholeBytes && !s.busy) begin
            if (s.byteNum == 4'h1 && s.opcode == `FSWP_OPC_WREN) begin
               next_s.write_latch_flag = 1'b1;
            end else if (s.byteNum == 4'h1 && s.opcode == `FSWP_OPC_WRDI) begin
               next_s.write_latch_flag = 1'b0;
            end else if (s.byteNum == 4'h2 && s.opcode == `FSWP_OPC_WRSR &&
                         s.write_latch_flag && !locked) begin
               // Only this path writes the guard, selector and lock bits.
               next_s.guard = s.wrData[`FSWP_S_GHI:`FSWP_S_GLO];
               next_s.guardEnd = s.wrData[`FSWP_S_TB];
               next_s.lockBit = s.wrData[`FSWP_S_LOCK];
               next_s.write_latch_flag = 1'b0;
               next_s.busy = 1'b1;
               next_s.busyCnt = 12'(`FSWP_TW_CYC);
            end else if (s.write_latch_flag && s.byteNum >= 4'h4 &&
                         (s.opcode == `FSWP_OPC_PROG || s.opcode == `FSWP_OPC_SE ||
                          s.opcode == `FSWP_OPC_BE32 || s.opcode == `FSWP_OPC_BE64)) begin
               // A hit on the guarded range discards the request entirely.
               if (!fswpHit(s.den2, s.guardEnd, s.guard, s.addr[18:16])) begin
                  next_s.write_latch_flag = 1'b0;
                  next_s.busy = 1'b1;
                  next_s.arrayGo = 1'b1;
                  next_s.arrayAddr = s.addr;
                  if (s.opcode == `FSWP_OPC_PROG) begin
                     next_s.arrayOp = FSWP_ARR_PROG;
                     next_s.busyCnt = 12'(`FSWP_TPP_CYC);
                  end else begin
                     next_s.arrayOp = (s.opcode == `FSWP_OPC_SE) ? FSWP_ARR_SECT
                                                               : FSWP_ARR_BLOCK;
                     next_s.busyCnt = 12'(`FSWP_TE_CYC);
                  end
               end
            end else if (s.write_latch_flag && s.byteNum == 4'h1 &&
                         (s.opcode == `FSWP_OPC_CE1 || s.opcode == `FSWP_OPC_CE2)) begin
               // Chip erase is refused while any range is guarded.
               if (s.guard == `FSWP_GUARD_RST || (s.guard[1:0] == 2'h0 &&
                   (s.den2 == `FSWP_DEN_1M || s.den2 == `FSWP_DEN_2M))) begin
                  next_s.write_latch_flag = 1'b0;
                  next_s.busy = 1'b1;
                  next_s.arrayGo = 1'b1;
                  next_s.arrayOp = FSWP_ARR_CHIP;
                  next_s.arrayAddr = 24'h00_0000;
                  next_s.busyCnt = 12'(`FSWP_TE_CYC);
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------
   // Reset stands in for power-up; non-volatile bits take factory values.
   always_ff @(posedge core_clk or negedge rstLocalN) begin
      if (!rstLocalN) begin
         s <= '0;
         s.csN1 <= 1'b1;
         s.csN2 <= 1'b1;
         s.csN3 <= 1'b1;
         s.lock1 <= 1'b1;
         s.lock2 <= 1'b1;
         s.write_latch_flag <= 1'b0;
         s.guard <= `FSWP_GUARD_RST;
         s.guardEnd <= `FSWP_TB_RST;
         s.lockBit <= `FSWP_LOCK_RST;
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign dataOut = s.dataOut;
   assign dataOutEn = s.dataOutEn;
   assign arrayGo = s.arrayGo;
   assign arrayOp = s.arrayOp;
   assign arrayAddr = s.arrayAddr;

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   default clocking fswpCk @(posedge core_clk); endclocking
   default disable iff (!rstLocalN || !clkEn);

   a_wren_sets_latch: assert property (
      csRise && wholeBytes && !s.busy && s.byteNum == 4'h1 && s.opcode == `FSWP_OPC_WREN
      |=> s.write_latch_flag) else $error("write enable did not set the latch");

   a_wrdi_clears_latch: assert property (
      csRise && wholeBytes && !s.busy && s.byteNum == 4'h1 && s.opcode == `FSWP_OPC_WRDI
      |=> !s.write_latch_flag) else $error("write disable did not clear the latch");

   a_busy_ignores_cmd: assert property (
      s.busy && s.busyCnt > 12'h002 && !s.write_latch_flag |=> !s.write_latch_flag [*2])
      else $error("latch set during busy");

   a_lock_refuses_write: assert property (
      csRise && s.lockBit && !s.lock2 && s.opcode == `FSWP_OPC_WRSR
      |=> $stable(s.guard) && $stable(s.guardEnd) && s.lockBit)
      else $error("status write passed a lock");

   a_reserved_reads_zero: assert property (
      sckFall && s.opcode == `FSWP_OPC_RDSR && s.byteNum != 4'h0 && s.bitPos == 3'h1
      |=> dataOutEn && !dataOut) else $error("reserved bit read as one");

   a_busy_ends_count: assert property (
      s.busy && s.busyCnt == 12'h000 && !csRise |=> !s.busy)
      else $error("busy outlived its count");

   a_guard_not_hit: assert property (
      arrayGo && arrayOp != FSWP_ARR_CHIP
      |-> !fswpHit(s.den2, s.guardEnd, s.guard, arrayAddr[18:16]) && s.busy && !s.write_latch_flag)
      else $error("write issued into the guarded range");

   a_partial_byte_drop: assert property (
      csRise && s.bitPos != 3'h0 |=> !arrayGo && $stable(s.guard) && !$rose(s.busy))
      else $error("partial byte instruction executed");

   a_status_write_busy: assert property (
      csRise && wholeBytes && !s.busy && s.write_latch_flag && !locked && s.byteNum == 4'h2 &&
      s.opcode == `FSWP_OPC_WRSR
      |=> s.busy && s.guard == $past(s.wrData[4:2]) ##1 s.busy)
      else $error("status write did not start busy");

   // With the lock bit clear the pin has no say over a status write.
   a_lock_clear_accept: assert property (
      csRise && wholeBytes && !s.busy && s.write_latch_flag && !s.lockBit && s.byteNum == 4'h2 &&
      s.opcode == `FSWP_OPC_WRSR |=> s.busy && !s.write_latch_flag)
      else $error("status write refused without lock");

   // Chip erase may only start when no block of the density is guarded.
   a_chip_erase_guard: assert property (
      arrayGo && arrayOp == FSWP_ARR_CHIP |-> s.guard[1:0] == 2'h0 &&
      (!s.guard[2] || s.den2 == `FSWP_DEN_1M || s.den2 == `FSWP_DEN_2M))
      else $error("chip erase issued while guarded");

   // Only the status read may answer while an operation runs.
   a_busy_read_silent: assert property (
      sckFall && !csRise && s.busy && s.opcode != `FSWP_OPC_RDSR |=> !dataOutEn)
      else $error("read answered during busy");

   // A status read shows the live status byte, MSB first.
   a_status_read_bit: assert property (
      sckFall && !csRise && !csFall && s.opcode == `FSWP_OPC_RDSR && s.byteNum != 4'h0
      |=> dataOutEn && dataOut == $past(statusByte[~s.bitPos]))
      else $error("status read bit mismatch");

endmodule // fswp_status_protect
